/* hdl/tgc_edge.sv */
// Rising and falling edge detector on a registered level.
`timescale 1ns/1ps
`default_nettype none
module tgc_edge (
  input wire logic clk,
  input wire logic rst,
  input wire logic lvl,
  output logic rise,
  output logic fall
);
  logic prev_q;
  logic prev_d;

  always_comb begin
    prev_d = lvl;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign rise = lvl && !prev_q;
  assign fall = !lvl && prev_q;
endmodule : tgc_edge
`default_nettype wire

/* hdl/tgc_ovf.sv */
// Eight-bit free running timer with a wrap pulse.
`timescale 1ns/1ps
`default_nettype none
module tgc_ovf
  import tgc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  output logic ovf_pulse
);
  logic [7:0] t8_q;
  logic [7:0] t8_d;
  logic ovf_q;
  logic ovf_d;

  always_comb begin
    t8_d = t8_q + 8'h01;
    ovf_d = (t8_q == TGC_T8_MAX) && (t8_d == TGC_T8_ZERO);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      t8_q <= TGC_T8_ZERO;
      ovf_q <= 1'b0;
    end else begin
      t8_q <= t8_d;
      ovf_q <= ovf_d;
    end
  end

  assign ovf_pulse = ovf_q;

  a_ovf_wrap: assert property (@(posedge clk) disable iff (rst)
    (t8_q == TGC_T8_MAX) |=> ovf_q) else $error("overflow pulse missing after wrap");
endmodule : tgc_ovf
`default_nettype wire

/* hdl/tgc_top.sv */
// Gate control logic for a 16-bit counter with an APB register slave.
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tgc_top
  import tgc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic por_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic gate_input_pin,
  output logic count_en,
  output logic irq
);
  // ***************************************************************
  // State
  // ***************************************************************
  logic [7:0] gate_q;
  logic [7:0] gate_d;
  logic on_q;
  logic on_d;
  logic [1:0] stat_q;
  logic [1:0] stat_d;
  logic [1:0] mask_q;
  logic [1:0] mask_d;
  logic tff_q;
  logic tff_d;
  logic sp_run_q;
  logic sp_run_d;
  logic val_q;
  logic val_d;
  // Last gate level, so that arming waits for a fresh active edge.
  logic raw_q;
  logic raw_d;
  logic cen_q;
  logic cen_d;
  logic irq_q;
  logic irq_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic ovf_pulse;
  logic src;
  logic src_rise;
  logic val_rise;
  logic val_fall;
  logic gate_raw;
  logic wr;
  logic rd;
  logic hit;

  tgc_ovf u_ovf (
    .clk(clk),
    .rst(rst),
    .ovf_pulse(ovf_pulse)
  );

  // ***************************************************************
  // Gate path
  // ***************************************************************
  always_comb begin
    case (gate_q[TGC_B_SS+:2])
      TGC_SS_PIN: src = gate_input_pin;
      TGC_SS_OVF: src = ovf_pulse;
      default: src = 1'b0;
    endcase
  end

  tgc_edge u_src_edge (
    .clk(clk),
    .rst(rst),
    .lvl(src),
    .rise(src_rise),
    .fall()
  );

  function automatic logic polar(input logic s, input logic pol);
    polar = pol ? s : !s;
  endfunction : polar

  always_comb begin
    gate_raw = gate_q[TGC_B_TM] ? tff_q : polar(src, gate_q[TGC_B_POL]);
    raw_d = gate_raw;
    if (gate_q[TGC_B_SPM]) begin
      val_d = gate_raw && sp_run_q;
    end else begin
      val_d = gate_raw;
    end
  end

  tgc_edge u_val_edge (
    .clk(clk),
    .rst(rst),
    .lvl(val_q),
    .rise(val_rise),
    .fall(val_fall)
  );

  // ***************************************************************
  // Toggle, single pulse, counter
  // ***************************************************************
  always_comb begin
    tff_d = tff_q;
    if (!on_q || !gate_q[TGC_B_TM]) begin
      tff_d = 1'b0;
    end else if (polar(src, gate_q[TGC_B_POL]) && src_rise == gate_q[TGC_B_POL]
                 && src_rise) begin
      tff_d = !tff_q;
    end else if (!gate_q[TGC_B_POL] && src_rise) begin
      tff_d = !tff_q;
    end
    sp_run_d = sp_run_q;
    if (!gate_q[TGC_B_SPM] || !gate_q[TGC_B_GO]) begin
      sp_run_d = 1'b0;
    end else if (gate_raw && !raw_q) begin
      sp_run_d = 1'b1;
    end
    cen_d = 1'b0;
    if (on_q) begin
      cen_d = gate_q[TGC_B_GE] ? val_d : 1'b1;
    end
    cnt_d = cen_q ? cnt_q + 16'h0001 : cnt_q;
  end

  // ***************************************************************
  // APB slave and registers
  // ***************************************************************
  assign wr = psel && penable && pwrite && pready_q;
  assign rd = psel && !penable;
  assign hit = (paddr == TGC_ADDR_GATE) || (paddr == TGC_ADDR_CTRL) ||
               (paddr == TGC_ADDR_STAT) || (paddr == TGC_ADDR_MASK) ||
               (paddr == TGC_ADDR_CNT);

  always_comb begin
    gate_d = gate_q;
    gate_d[TGC_B_VAL] = 1'b0;
    on_d = on_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (wr && pstrb[0]) begin
      case (paddr)
        TGC_ADDR_GATE: begin
          gate_d = pwdata[7:0];
          gate_d[TGC_B_VAL] = 1'b0;
        end
        TGC_ADDR_CTRL: on_d = pwdata[TGC_B_ON];
        TGC_ADDR_STAT: stat_d = stat_q & ~pwdata[1:0];
        TGC_ADDR_MASK: mask_d = pwdata[1:0];
        default: on_d = on_q;
      endcase
    end
    if (gate_q[TGC_B_SPM] && sp_run_q && !val_d) begin
      gate_d[TGC_B_GO] = 1'b0;
    end
    if (val_fall) begin
      stat_d[TGC_B_EVT] = 1'b1;
    end
    if (ovf_pulse) begin
      stat_d[TGC_B_OVF] = 1'b1;
    end
    irq_d = |(stat_d & mask_d);
    pready_d = psel && penable && !pready_q;
    pslverr_d = pready_d && !hit;
    prdata_d = prdata_q;
    if (rd) begin
      case (paddr)
        TGC_ADDR_GATE: prdata_d = {24'h000000, gate_q[7:3], val_q, gate_q[1:0]};
        TGC_ADDR_CTRL: prdata_d = {31'h00000000, on_q};
        TGC_ADDR_STAT: prdata_d = {30'h00000000, stat_q};
        TGC_ADDR_MASK: prdata_d = {30'h00000000, mask_q};
        TGC_ADDR_CNT: prdata_d = {16'h0000, cnt_q};
        default: prdata_d = TGC_ZERO32;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tff_q <= 1'b0;
      sp_run_q <= 1'b0;
      raw_q <= 1'b0;
      val_q <= 1'b0;
      cen_q <= 1'b0;
      irq_q <= 1'b0;
      cnt_q <= TGC_CNT_RST;
      prdata_q <= TGC_ZERO32;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      stat_q <= TGC_IRQ_RST;
    end else begin
      tff_q <= tff_d;
      sp_run_q <= sp_run_d;
      raw_q <= raw_d;
      val_q <= val_d;
      cen_q <= cen_d;
      irq_q <= irq_d;
      cnt_q <= cnt_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      stat_q <= stat_d;
    end
  end

  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      gate_q <= TGC_GATE_RST;
      on_q <= 1'b0;
      mask_q <= TGC_IRQ_RST;
    end else begin
      gate_q <= gate_d;
      on_q <= on_d;
      mask_q <= mask_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign count_en = cen_q;
  assign irq = irq_q;

  // ***************************************************************
  // Checks
  // ***************************************************************
  sequence s_armed_run;
    gate_q[TGC_B_SPM] && sp_run_q;
  endsequence

  a_off_no_count: assert property (@(posedge clk) disable iff (rst)
    !on_q |=> !cen_q) else $error("counter enabled while off");
  a_free_count: assert property (@(posedge clk) disable iff (rst)
    (on_q && !gate_q[TGC_B_GE]) |=> cen_q) else $error("free count missing");
  a_gated_count: assert property (@(posedge clk) disable iff (rst)
    (on_q && gate_q[TGC_B_GE]) |=> (cen_q == val_q)) else $error("gate ignored");
  a_tff_held: assert property (@(posedge clk) disable iff (rst)
    (!gate_q[TGC_B_TM] || !on_q) |=> !tff_q) else $error("toggle flop not held");
  a_reserved_src: assert property (@(posedge clk) disable iff (rst)
    gate_q[1] |-> !src) else $error("reserved source not quiet");
  a_armed_clear: assert property (@(posedge clk) disable iff (rst)
    (s_armed_run ##0 !val_d) |=> !gate_q[TGC_B_GO]) else $error("armed bit kept");
  a_event_flag: assert property (@(posedge clk) disable iff (rst)
    val_fall |=> stat_q[TGC_B_EVT]) else $error("gate event lost");
  a_pol_level: assert property (@(posedge clk) disable iff (rst)
    (!gate_q[TGC_B_TM] && !gate_q[TGC_B_SPM] && gate_q[TGC_B_POL])
    |=> (val_q == $past(src))) else $error("polarity wrong");
endmodule : tgc_top
`default_nettype wire

/* include/tgc_pkg.sv */
// Package of constants for the gate control block.
// Summary of operation
// - With the counter on, gate enable 1 lets the gate control counting, 0 counts freely; ignored when off.
// - Polarity 1 counts while the gate is high, polarity 0 counts while the gate is low; in toggle mode the code ignores polarity.
// - Toggle mode bit set routes the gate through a toggle flip-flop; cleared holds that flip-flop clear.
// - In toggle mode, with the counter on, the flip-flop changes state on every rising edge of the selected gate.
// - Single-pulse mode bit 1 lets the single-pulse logic own the gate; 0 makes it inactive.
// - While the armed bit reads 1 the block waits for a gate edge to start an acquisition.
// - Hardware clears the armed bit at completion; it reads 0 when done or never started.
// - The read-only gate level bit shows the gate that would reach the counter, whatever gate enable says.
// - Source code 00 selects the gate pin, 01 the timer overflow, 10 and 11 are reserved.
// - Writable gate bits reset to 0 on power-on and brown-out, keep their value on other resets.
// - Each falling edge of the gate level sets the gate event flag, even with gate enable clear.
// - An 8-bit timer wrap from its maximum to zero gives a one-cycle overflow gate pulse.
// - Once armed, counting starts at the next active gate edge, the armed bit clears at the trailing edge.
// - Clearing the counter on bit stops the counter and clears the toggle flip-flop.
package tgc_pkg;
  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [11:0] TGC_ADDR_GATE = 12'h000;
  localparam logic [11:0] TGC_ADDR_CTRL = 12'h004;
  localparam logic [11:0] TGC_ADDR_STAT = 12'h008;
  localparam logic [11:0] TGC_ADDR_MASK = 12'h00C;
  localparam logic [11:0] TGC_ADDR_CNT = 12'h010;
  // ***************************************************************
  // Register field positions and constants
  // ***************************************************************
  localparam int TGC_B_GE = 7;
  localparam int TGC_B_POL = 6;
  localparam int TGC_B_TM = 5;
  localparam int TGC_B_SPM = 4;
  localparam int TGC_B_GO = 3;
  localparam int TGC_B_VAL = 2;
  localparam int TGC_B_SS = 0;
  localparam int TGC_B_ON = 0;
  localparam int TGC_B_EVT = 0;
  localparam int TGC_B_OVF = 1;
  localparam logic [7:0] TGC_GATE_RST = 8'h00;
  localparam logic [1:0] TGC_SS_PIN = 2'h0;
  localparam logic [1:0] TGC_SS_OVF = 2'h1;
  localparam logic [7:0] TGC_T8_MAX = 8'hFF;
  localparam logic [7:0] TGC_T8_ZERO = 8'h00;
  localparam logic [15:0] TGC_CNT_RST = 16'h0000;
  localparam logic [1:0] TGC_IRQ_RST = 2'h0;
  localparam logic [31:0] TGC_ZERO32 = 32'h00000000;
endpackage : tgc_pkg

/* testbench/tgc_gate_src.sv */
// Model of the external source that drives the gate pin.
`timescale 1ns/1ps
`default_nettype none
module tgc_gate_src (
  input wire logic clk,
  output logic pin
);
  initial pin = 1'b0;
  // Sets a new level at once, then waits six rising edges for it to settle.
  task automatic lvl(input logic v);
    pin <= v;
    repeat (6) @(posedge clk);
  endtask : lvl
endmodule : tgc_gate_src
`default_nettype wire

/* testbench/tgc_top_tb.sv */
// Self-checking testbench for the gate control block.
`timescale 1ns/1ps
`default_nettype none
module tgc_top_tb
  import tgc_pkg::*;
;
  logic clk = 1'b0;
  logic rst, por_n, psel, penable, pwrite, pready, pslverr, pin, count_en, irq, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, cnt0;
  logic [3:0] pstrb;
  int bad_count = 0;
  int checked = 0;
  tgc_top dut (.clk(clk), .rst(rst), .por_n(por_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gate_input_pin(pin), .count_en(count_en), .irq(irq));
  tgc_gate_src src (.clk(clk), .pin(pin));
  always #20 clk = ~clk;
  task automatic stop_test;
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    apb(a, 1'b0, 32'h00000000);
  endtask : rd
  initial begin
    repeat (6000) @(posedge clk);
    bad_count++;
    stop_test();
  end
  // ***************************************************************
  // Tests
  // ***************************************************************
  initial begin
    rst = 1'b1;
    por_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    por_n <= 1'b1;
    @(posedge clk);
    rd(TGC_ADDR_GATE);
    chk(rdat & 32'hFFFFFFFB, 32'h00000000);
    chk(rdat[3], 32'h00000000);
    rd(12'hFE0);
    chk(rerr, 32'h00000001);
    wr(TGC_ADDR_CTRL, 32'h00000001);
    src.lvl(1'b1);
    chk(count_en, 32'h00000001);
    rd(TGC_ADDR_CNT);
    cnt0 = rdat;
    rd(TGC_ADDR_CNT);
    chk(rdat > cnt0, 32'h00000001);
    src.lvl(1'b0);
    chk(count_en, 32'h00000001);
    wr(TGC_ADDR_GATE, 32'h000000C0);
    chk(count_en, 32'h00000000);
    src.lvl(1'b1);
    chk(count_en, 32'h00000001);
    wr(TGC_ADDR_GATE, 32'h00000080);
    chk(count_en, 32'h00000000);
    src.lvl(1'b0);
    chk(count_en, 32'h00000001);
    wr(TGC_ADDR_GATE, 32'h00000040);
    wr(TGC_ADDR_STAT, 32'h00000003);
    wr(TGC_ADDR_MASK, 32'h00000001);
    src.lvl(1'b1);
    rd(TGC_ADDR_GATE);
    chk(rdat & 32'h4, 32'h4);
    chk(irq, 32'h00000000);
    src.lvl(1'b0);
    rd(TGC_ADDR_GATE);
    chk(rdat & 32'h4, 32'h0);
    chk(irq, 32'h00000001);
    rd(TGC_ADDR_STAT);
    chk(rdat & 32'h1, 32'h1);
    pstrb <= 4'hE;
    wr(TGC_ADDR_MASK, 32'h00000000);
    chk(irq, 32'h00000001);
    pstrb <= 4'hF;
    wr(TGC_ADDR_MASK, 32'h00000000);
    chk(irq, 32'h00000000);
    wr(TGC_ADDR_MASK, 32'hFFFFFFFD);
    rd(TGC_ADDR_MASK);
    chk(rdat, 32'h00000001);
    wr(TGC_ADDR_STAT, 32'h00000001);
    chk(irq, 32'h00000000);
    src.lvl(1'b1);
    for (int c = 3; c >= 2; c--) begin
      wr(TGC_ADDR_GATE, 32'h000000C0 | c);
      repeat (6) @(posedge clk);
      chk(count_en, 32'h00000000);
      rd(TGC_ADDR_GATE);
      chk(rdat & 32'h4, 32'h0);
    end
    wr(TGC_ADDR_GATE, 32'h000000C0);
    repeat (6) @(posedge clk);
    chk(count_en, 32'h00000001);
    wr(TGC_ADDR_GATE, 32'h00000041);
    wr(TGC_ADDR_STAT, 32'h00000003);
    repeat (300) @(posedge clk);
    rd(TGC_ADDR_STAT);
    chk(rdat & 32'h3, 32'h3);
    src.lvl(1'b0);
    wr(TGC_ADDR_GATE, 32'h000000E0);
    chk(count_en, 32'h00000000);
    src.lvl(1'b1);
    src.lvl(1'b0);
    chk(count_en, 32'h00000001);
    src.lvl(1'b1);
    src.lvl(1'b0);
    chk(count_en, 32'h00000000);
    src.lvl(1'b1);
    src.lvl(1'b0);
    wr(TGC_ADDR_CTRL, 32'h00000000);
    chk(count_en, 32'h00000000);
    rd(TGC_ADDR_CNT);
    cnt0 = rdat;
    rd(TGC_ADDR_CNT);
    chk(rdat, cnt0);
    wr(TGC_ADDR_CTRL, 32'h00000001);
    repeat (6) @(posedge clk);
    chk(count_en, 32'h00000000);
    src.lvl(1'b1);
    wr(TGC_ADDR_GATE, 32'h000000D0);
    repeat (6) @(posedge clk);
    chk(count_en, 32'h00000000);
    src.lvl(1'b0);
    wr(TGC_ADDR_GATE, 32'h000000D8);
    rd(TGC_ADDR_GATE);
    chk(rdat & 32'h8, 32'h8);
    src.lvl(1'b1);
    chk(count_en, 32'h00000001);
    src.lvl(1'b0);
    chk(count_en, 32'h00000000);
    rd(TGC_ADDR_GATE);
    chk(rdat & 32'h8, 32'h0);
    src.lvl(1'b1);
    chk(count_en, 32'h00000000);
    wr(TGC_ADDR_GATE, 32'h000000D8);
    repeat (6) @(posedge clk);
    chk(count_en, 32'h00000000);
    src.lvl(1'b0);
    src.lvl(1'b1);
    chk(count_en, 32'h00000001);
    src.lvl(1'b0);
    wr(TGC_ADDR_GATE, 32'h000000E1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(TGC_ADDR_GATE);
    chk(rdat & 32'hF3, 32'hE1);
    por_n <= 1'b0;
    repeat (2) @(posedge clk);
    por_n <= 1'b1;
    @(posedge clk);
    rd(TGC_ADDR_GATE);
    chk(rdat & 32'hFB, 32'h00);
    stop_test();
  end
endmodule : tgc_top_tb
`default_nettype wire
